// ---- include/sema_slots_pkg.sv ----
/*
 Constants for semaphore lock slots three to seven: offsets, field positions,
 reset values and bus answer timing.
 Assumes a 32-bit APB with byte addresses; each slot takes one aligned word.
*/
package sema_slots_pkg;

    localparam int unsigned addr_width = 12;
    localparam int unsigned data_width = 32;
    localparam int unsigned slot_count = 5;
    localparam int unsigned first_slot = 3;

    localparam logic [11:0] lock_slot_3_offset = 12'h00c;
    localparam logic [11:0] lock_slot_4_offset = 12'h010;
    localparam logic [11:0] lock_slot_5_offset = 12'h014;
    localparam logic [11:0] lock_slot_6_offset = 12'h018;
    localparam logic [11:0] lock_slot_7_offset = 12'h01c;

    localparam int unsigned lock_bit_pos = 0;
    localparam logic lock_free = 1'b0;
    localparam logic lock_held = 1'b1;
    localparam logic lock_reset_value = 1'b0;
    localparam logic [31:0] reserved_read_value = 32'h0000_0000;
    localparam logic [31:0] unmapped_read_value = 32'h0000_0000;

    // Bus answers in the first access cycle; no wait states
    localparam int unsigned access_wait_cycles = 0;

    typedef enum logic [1:0] {
        apb_idle,
        apb_setup,
        apb_access
    } apb_phase_type;

endpackage : sema_slots_pkg

// ---- rtl/slot_decoder.sv ----
/*
 Address decoder for the five lock slot registers.
 Assumes a word-aligned byte address; returns a one-hot slot select and a hit flag.
*/
`timescale 1ns/1ps
module slot_decoder
    import sema_slots_pkg::*;
(
    // Address in
    input wire logic [addr_width-1:0] paddr,
    // Decoded select
    output logic [slot_count-1:0] slot_sel,
    output logic hit
);

    always_comb begin
        slot_sel = '0;
        if (paddr == lock_slot_3_offset) begin
            slot_sel[0] = 1'b1;
        end else if (paddr == lock_slot_4_offset) begin
            slot_sel[1] = 1'b1;
        end else if (paddr == lock_slot_5_offset) begin
            slot_sel[2] = 1'b1;
        end else if (paddr == lock_slot_6_offset) begin
            slot_sel[3] = 1'b1;
        end else if (paddr == lock_slot_7_offset) begin
            slot_sel[4] = 1'b1;
        end
        hit = |slot_sel;
    end

endmodule : slot_decoder

// ---- rtl/lock_slot.sv ----
/*
 One semaphore lock bit with test-and-take on read and release on writing zero.
 Assumes at most one bus access per cycle, so take and release never collide.
*/
`timescale 1ns/1ps
module lock_slot
    import sema_slots_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Access strobes, one cycle each
    input wire logic take_read,
    input wire logic release_write,
    input wire logic write_bit,
    // Lock state
    output logic lock_q
);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_q <= lock_reset_value;
        end else if (take_read && lock_q == lock_free) begin
            lock_q <= lock_held;
        end else if (release_write && write_bit == lock_free) begin
            lock_q <= lock_free;
        end
    end

endmodule : lock_slot

// ---- rtl/sema_lock_slots.sv ----
/*
 Semaphore lock slots three to seven behind an APB slave, with a mirror of each
 lock bit for the shared status register.
 Assumes one APB master arbitrating both cores, synchronous inputs on pclk.
*/
`timescale 1ns/1ps
module sema_lock_slots
    import sema_slots_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [addr_width-1:0] paddr,
    input wire logic [data_width-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [data_width-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Status mirror
    output logic lock_mirror_bit_3,
    output logic lock_mirror_bit_4,
    output logic lock_mirror_bit_5,
    output logic lock_mirror_bit_6,
    output logic lock_mirror_bit_7
);

    logic [slot_count-1:0] slot_sel;
    logic hit;
    logic [slot_count-1:0] lock_q;
    logic setup_phase;
    logic do_read;
    logic do_write;
    logic [data_width-1:0] prdata_d;
    logic [slot_count-1:0] mirror_q;

    slot_decoder u_decoder (
        .paddr(paddr),
        .slot_sel(slot_sel),
        .hit(hit)
    );

    // Act in the setup cycle so the answer flops are ready for the access edge
    assign setup_phase = psel && !penable;
    assign do_read = setup_phase && !pwrite;
    // Lock bit sits in byte lane zero; a write without it leaves the lock alone
    assign do_write = setup_phase && pwrite && pstrb[0];

    genvar g;
    generate
        for (g = 0; g < slot_count; g++) begin : g_slot
            lock_slot u_slot (
                .pclk(pclk),
                .presetn(presetn),
                .take_read(do_read && slot_sel[g]),
                .release_write(do_write && slot_sel[g]),
                .write_bit(pwdata[lock_bit_pos]),
                .lock_q(lock_q[g])
            );
        end
    endgenerate

    // Read data holds the value before the take; reserved bits stay zero
    always_comb begin
        prdata_d = reserved_read_value;
        for (int i = 0; i < slot_count; i++) begin
            if (slot_sel[i]) begin
                prdata_d[lock_bit_pos] = lock_q[i];
            end
        end
        if (!hit) begin
            prdata_d = unmapped_read_value;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (do_read) begin
            prdata <= prdata_d;
        end
    end

    // Ready for exactly the access cycle; error on unmapped address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup_phase;
            pslverr <= setup_phase && !hit;
        end
    end

    // Mirror follows the next lock state, so it changes on the same edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mirror_q <= {slot_count{lock_reset_value}};
        end else begin
            for (int i = 0; i < slot_count; i++) begin
                if (do_read && slot_sel[i] && lock_q[i] == lock_free) begin
                    mirror_q[i] <= lock_held;
                end else if (do_write && slot_sel[i] && pwdata[lock_bit_pos] == lock_free) begin
                    mirror_q[i] <= lock_free;
                end
            end
        end
    end

    assign lock_mirror_bit_3 = mirror_q[0];
    assign lock_mirror_bit_4 = mirror_q[1];
    assign lock_mirror_bit_5 = mirror_q[2];
    assign lock_mirror_bit_6 = mirror_q[3];
    assign lock_mirror_bit_7 = mirror_q[4];

endmodule : sema_lock_slots

// ---- verification/sema_slots_sva.sv ----
/* Checker for the lock slot block, slot three taken as sample.
   Sees only top ports; bound from the bench file. */
`timescale 1ns/1ps
module sema_slots_sva
    import sema_slots_pkg::*;
(
    // Bus and status
    input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
    input wire logic [addr_width-1:0] paddr,
    input wire logic [data_width-1:0] pwdata, prdata,
    input wire logic [3:0] pstrb,
    input wire logic lock_mirror_bit_3, lock_mirror_bit_4, lock_mirror_bit_5, lock_mirror_bit_6, lock_mirror_bit_7
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic rd3;
    assign rd3 = psel && !penable && !pwrite && paddr == 12'h00c;
    upper_zero_a: assert property (pready && !pwrite |-> prdata[31:1] == 31'h0)
        else $error("upper read bits not zero");
    free_take_a: assert property (rd3 && !lock_mirror_bit_3 |=> !prdata[0] && lock_mirror_bit_3)
        else $error("free read did not take");
    release_a: assert property (psel && !penable && pwrite && paddr == 12'h00c && pstrb[0] && !pwdata[0]
        |=> !lock_mirror_bit_3) else $error("release failed");
    reset_free_a: assert property (disable iff (1'b0) !presetn |-> !lock_mirror_bit_3 && !lock_mirror_bit_7)
        else $error("lock not free in reset");
    mirror_cause_a: assert property ($changed(lock_mirror_bit_3) |-> $past(psel && !penable))
        else $error("mirror changed without access");
    held_read_a: assert property (rd3 && lock_mirror_bit_3 |=> (prdata[0] && lock_mirror_bit_3) [*2])
        else $error("held slot read wrong");
endmodule : sema_slots_sva

// ---- verification/apb_core_model.sv ----
/* APB master standing for the cores.
   Assumes one cycle per edge; released address and data lines are inverted. */
`timescale 1ns/1ps
module apb_core_model (
    // Bus
    input wire logic pclk, pready, pslverr,
    input wire logic [31:0] prdata,
    output logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0,
    output logic [11:0] paddr = 12'h000,
    output logic [31:0] pwdata = 32'h0,
    output logic [3:0] pstrb = 4'h0
);
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
        output logic [32:0] r);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = {pslverr, prdata};
        psel <= 1'b0; penable <= 1'b0; paddr <= ~a; pwdata <= ~d;
    endtask : xfer
endmodule : apb_core_model

// ---- verification/hw_semaphore_slots_3_to_7_bench.sv ----
/* Bench: take, hold, refused and real release on all slots, plus an unmapped read.
   Assumes the core model drives the bus. */
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_errors++; \
    $display("wrong value t=%0t got %h exp %h", $time, a, e); end end
module hw_semaphore_slots_3_to_7_bench;
    logic pclk = 1'b0, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [4:0] mir;
    logic [32:0] r;
    int n_errors = 0, n_tests = 0;
    always #20 pclk = ~pclk;
    sema_lock_slots sema_lock_slots_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .lock_mirror_bit_3(mir[0]), .lock_mirror_bit_4(mir[1]),
        .lock_mirror_bit_5(mir[2]), .lock_mirror_bit_6(mir[3]), .lock_mirror_bit_7(mir[4]));
    apb_core_model apb_core_model_i (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
    task automatic test_done;
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : test_done
    initial begin
        repeat (5000) @(posedge pclk);
        n_errors++;
        test_done();
    end
    initial begin
        // Drive reset from unknown so the design sees a falling edge
        presetn <= 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        `CHK(mir, 5'h00)
        for (int i = 0; i < 5; i++) begin
            // Each slot: take, held reread, refused writes leave the lock held, release, take again
            apb_core_model_i.xfer(1'b0, 12'h00c + 12'(4 * i), 32'h0, 4'h0, r);
            `CHK(r, 33'h0)
            `CHK(mir[i], 1'b1)
            apb_core_model_i.xfer(1'b0, 12'h00c + 12'(4 * i), 32'h0, 4'h0, r);
            `CHK(r, 33'h1)
            apb_core_model_i.xfer(1'b1, 12'h00c + 12'(4 * i), 32'h0, 4'he, r);
            apb_core_model_i.xfer(1'b1, 12'h00c + 12'(4 * i), 32'h1, 4'hf, r);
            `CHK(mir[i], 1'b1)
            apb_core_model_i.xfer(1'b1, 12'h00c + 12'(4 * i), 32'hffff_fffe, 4'hf, r);
            `CHK(mir[i], 1'b0)
            apb_core_model_i.xfer(1'b0, 12'h00c + 12'(4 * i), 32'h0, 4'h0, r);
            `CHK(r, 33'h0)
        end
        apb_core_model_i.xfer(1'b0, 12'h020, 32'h0, 4'h0, r);
        `CHK(r, {1'b1, 32'h0})
        `CHK(mir, 5'h1f)
        test_done();
    end
endmodule : hw_semaphore_slots_3_to_7_bench
bind sema_lock_slots sema_slots_sva sema_slots_sva_i (.*);
